// ---- common/ltl_consts.vh ----
`ifndef LTL_CONSTS_VH
`define LTL_CONSTS_VH
`define LTL_ADDR_MISC 12'h450
`define LTL_ADDR_ERR 12'h454
`define LTL_ADDR_NAK 12'h458
`define LTL_ADDR_CTRL 12'h45C
`define LTL_ADDR_TXDBG 12'h460
`define LTL_ADDR_RXDBG 12'h464
`define LTL_ADDR_MTXDBG 12'h468
`define LTL_ADDR_MRXDBG 12'h46C
`define LTL_ADDR_LADBG 12'h470
`define LTL_ADDR_TLA 12'h4C0
`define LTL_ADDR_TLB 12'h4C4
`define LTL_RST_MISC 32'h0000_078D
`define LTL_RST_ERR_HI 13'h03E3
`define LTL_RST_RX_ACK 3'h3
`define LTL_RST_TX_ACK 3'h0
`define LTL_RST_CTRL 32'h0CCC_2C81
`define LTL_RST_TXDBG 32'h0000_0070
`define LTL_RST_RXDBG 32'h0000_0000
`define LTL_RST_MRXDBG 32'h0000_0000
`define LTL_RST_MTXDBG 32'h0098_0029
`define LTL_RST_LADBG 32'h0000_00CB
`define LTL_RST_TLA 14'h0001
`define LTL_RST_TLB 5'h08
`define LTL_PM_ACK_MAX 3'h6
`define LTL_MISC_WMASK 32'h0000_07FF
`define LTL_CTRL_WMASK 32'h7FFF_FFFD
`define LTL_TLA_WMASK 14'h0701
`define LTL_TLB_WMASK 5'h1F
`endif

// ---- verilog/ltl_link_txn_regs.v ----
// Summary of operation
// R1 - Bits 0..2 report nullified TLP, TLP length mismatch, bad sequence number.
// R2 - Bit 3 reports retry buffer full.
// R3 - Bits 4 and 5 report correctable and uncorrectable ECC errors.
// R4 - Bits 6..9 report replay timeout, link packet CRC, TLP CRC, nullified CRC.
// R5 - Writable receive PM ack count bits 14:12, range 0..6, reset 3.
// R6 - Writable transmit PM ack count bits 18:16, range 0..6, reset 0.
// R7 - Receiver NAK sequence in bits 11:0, receiver NAK flag in bit 15.
// R8 - Transmitter NAK sequence in bits 27:16, transmitter NAK flag in bit 31.
// R9 - Nullified packets generated only while control bit 0 set; resets to 1.
// R10 - Link layer reset bit 1 cleared by writing one, resets to 0.
// R11 - Arbitration mode bit 4 chooses sticky round robin or credit-qualified moves.
// R12 - Receive threshold bits 7:4, writable, resets to 8.
// R13 - De-skew ranges Gen1 19:16, Gen2 23:20, Gen3 27:24, each reset 0xC.
// R14 - FTS skew Gen1 bits 12:10 reset 3, Gen2 bits 15:13 reset 1.
// R15 - Port bifurcation enabled only while bit 29 set; resets to 0.
// R16 - Read-only x16 back-to-back count in bits 31:28, cleared by miscellaneous bit 2.
// R17 - Gen1/2 de-skew reset count bits 10:8, writable, resets to 7.
// R18 - Gen3 idle qualifies data validity while bit 7 set; resets to 1.
// R19 - VGA decode enabled when bit 0 is 1; resets to 1.
// R20 - Read-only bits 1 and 2 hide MSI and power capabilities; reset 0.
// R21 - Read-only bit 5 disables memory sharing switch-wide, only from port 0.
// R22 - Cut-through threshold bits 2:1: middle, or one to three cycles earlier.
`timescale 1ns/1ps
`include "ltl_consts.vh"
module ltl_link_txn_regs #(
	parameter IS_PORT0 = 1'b1
) (
	input wire ref_clk_in,
	input wire reset_in,
	input wire [11:0] addr_in,
	input wire [31:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [31:0] rdata_out,
	input wire [9:0] err_event_in,
	input wire rx_nak_in,
	input wire [11:0] rx_nak_seq_in,
	input wire tx_nak_in,
	input wire [11:0] tx_nak_seq_in,
	input wire x16_b2b_tlp_in,
	input wire dll_reset_req_in,
	input wire [1:0] cap_dis_strap_in,
	input wire mem_share_dis_strap_in,
	input wire arb_credit_ok_in,
	input wire arb_req_pending_in,
	output wire arb_move_out,
	output reg nullify_enable_out,
	output reg dll_reset_out,
	output reg bifurcate_enable_out,
	output reg g3_idle_qualify_enable_out,
	output reg vga_decode_out,
	output reg msi_cap_hide_out,
	output reg pwr_cap_hide_out,
	output reg mem_share_dis_out,
	output reg [1:0] ct_early_cycles_out,
	output reg [3:0] rx_threshold_out,
	output reg [2:0] rx_pm_ack_out,
	output reg [2:0] tx_pm_ack_out,
	output reg [3:0] deskew_g1_out,
	output reg [3:0] deskew_g2_out,
	output reg [3:0] deskew_g3_out,
	output reg [2:0] fts_g1_out,
	output reg [2:0] fts_g2_out,
	output reg [2:0] deskew_rst_cnt_out
);

	reg [31:0] misc_q;
	reg [3:0] b2b_cnt_q;
	reg [9:0] err_q;
	reg [2:0] rx_ack_q;
	reg [2:0] tx_ack_q;
	reg [11:0] rx_seq_q;
	reg [11:0] tx_seq_q;
	reg rx_nak_q;
	reg tx_nak_q;
	reg [31:0] ctrl_q;
	reg [31:0] ladbg_q;
	reg [13:0] tla_q;
	reg [4:0] tlb_q;
	reg [31:0] rdata_d;
	wire wr_misc;
	wire wr_err;
	wire wr_ctrl;
	wire wr_tla;
	wire wr_tlb;
	wire wr_ladbg;
	reg dll_rst_q;
	wire [2:0] strap_raw;
	wire [2:0] strap_sync;
	wire [9:0] err_d;
	wire rx_ack_ok;
	wire tx_ack_ok;
	wire [31:0] rd_misc;
	wire [31:0] rd_err;
	wire [31:0] rd_nak;
	wire [31:0] rd_ctrl;
	wire [31:0] rd_tla;
	wire [31:0] rd_tlb;
	genvar gi;

	assign wr_misc = wr_in && (addr_in == `LTL_ADDR_MISC);
	assign wr_err = wr_in && (addr_in == `LTL_ADDR_ERR);
	assign wr_ctrl = wr_in && (addr_in == `LTL_ADDR_CTRL);
	assign wr_tla = wr_in && (addr_in == `LTL_ADDR_TLA);
	assign wr_tlb = wr_in && (addr_in == `LTL_ADDR_TLB);
	assign wr_ladbg = wr_in && (addr_in == `LTL_ADDR_LADBG);

	// Sticky mode stays while a request waits; otherwise move only with enough credit.
	assign arb_move_out = tlb_q[4] ? !arb_req_pending_in : arb_credit_ok_in; // [R11]

	// Straps come from pins; each passes four flip-flops before it is used.
	assign strap_raw = {mem_share_dis_strap_in, cap_dis_strap_in};

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg hold_q;
			always @(posedge ref_clk_in) begin
				if (reset_in) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					hold_q <= 1'b0;
				end else begin
					s1_q <= strap_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// A new level counts only once the last two stages agree.
					if (s2_q == s3_q) begin
						hold_q <= s3_q;
					end
				end
			end
			assign strap_sync[gi] = hold_q;
		end
	endgenerate

	// Each event pulse sets its own flag; the flags hold until reset.
	generate
		for (gi = 0; gi < 10; gi = gi + 1) begin : g_err
			assign err_d[gi] = err_q[gi] | err_event_in[gi]; // [R1] [R2] [R3] [R4]
		end
	endgenerate

	// Count values above the valid range leave the field as it was.
	assign rx_ack_ok = wdata_in[14:12] <= `LTL_PM_ACK_MAX; // [R5]
	assign tx_ack_ok = wdata_in[18:16] <= `LTL_PM_ACK_MAX; // [R6]

	// Read words of the registers that mix fields from several places.
	assign rd_misc = {b2b_cnt_q, misc_q[27:0]}; // [R16]
	assign rd_err = {`LTL_RST_ERR_HI, tx_ack_q, 1'b1, rx_ack_q, 2'b00, err_q};
	assign rd_nak = {tx_nak_q, 3'h0, tx_seq_q, rx_nak_q, 3'h0, rx_seq_q}; // [R7] [R8]
	assign rd_ctrl = {ctrl_q[31:2], dll_rst_q, ctrl_q[0]}; // [R10]
	assign rd_tla = {18'h00000, tla_q};
	assign rd_tlb = {27'h0000000, tlb_q};

	// Miscellaneous link control.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			misc_q <= `LTL_RST_MISC;
		end else if (wr_misc) begin
			misc_q <= wdata_in & `LTL_MISC_WMASK;
		end
	end

	// The back-to-back counter saturates so that a long burst never wraps to zero.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			b2b_cnt_q <= 4'h0;
		end else if (misc_q[2]) begin
			b2b_cnt_q <= 4'h0; // [R16]
		end else if (x16_b2b_tlp_in && b2b_cnt_q != 4'hF) begin
			b2b_cnt_q <= b2b_cnt_q + 4'h1; // [R16]
		end
	end

	// Event flags are sticky until reset; software cannot clear read-only flags.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			err_q <= 10'h000;
			rx_ack_q <= `LTL_RST_RX_ACK;
			tx_ack_q <= `LTL_RST_TX_ACK;
		end else begin
			err_q <= err_d; // [R1] [R2] [R3] [R4]
			if (wr_err && rx_ack_ok) begin
				rx_ack_q <= wdata_in[14:12]; // [R5]
			end
			if (wr_err && tx_ack_ok) begin
				tx_ack_q <= wdata_in[18:16]; // [R6]
			end
		end
	end

	// Receiver NAK record: the latest sequence number and a sticky flag.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			rx_seq_q <= 12'h000;
			rx_nak_q <= 1'b0;
		end else if (rx_nak_in) begin
			rx_seq_q <= rx_nak_seq_in; // [R7]
			rx_nak_q <= 1'b1; // [R7]
		end
	end

	// Transmitter NAK record: the latest sequence number and a sticky flag.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			tx_seq_q <= 12'h000;
			tx_nak_q <= 1'b0;
		end else if (tx_nak_in) begin
			tx_seq_q <= tx_nak_seq_in; // [R8]
			tx_nak_q <= 1'b1; // [R8]
		end
	end

	// Link layer control; the write mask keeps read-only bits and bit 1 out of it.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			ctrl_q <= `LTL_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= (wdata_in & `LTL_CTRL_WMASK) | (ctrl_q & ~`LTL_CTRL_WMASK);
		end
	end

	// The reset request wins over a write-one clear in the same cycle.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			dll_rst_q <= 1'b0;
		end else if (dll_reset_req_in) begin
			dll_rst_q <= 1'b1; // [R10]
		end else if (wr_ctrl && wdata_in[1]) begin
			dll_rst_q <= 1'b0; // [R10]
		end
	end

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			ladbg_q <= `LTL_RST_LADBG;
		end else if (wr_ladbg) begin
			ladbg_q <= wdata_in;
		end
	end

	// Read-only capability bits follow the synchronised straps after reset.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			tla_q <= `LTL_RST_TLA;
		end else begin
			tla_q[2:1] <= strap_sync[1:0]; // [R20]
			tla_q[5] <= IS_PORT0 ? strap_sync[2] : 1'b0; // [R21]
			if (wr_tla) begin
				tla_q[0] <= wdata_in[0]; // [R19]
				tla_q[10:8] <= wdata_in[10:8];
			end
		end
	end

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			tlb_q <= `LTL_RST_TLB;
		end else if (wr_tlb) begin
			tlb_q <= wdata_in[4:0] & `LTL_TLB_WMASK; // [R22]
		end
	end

	// Link layer enables are registered copies of their bits.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			nullify_enable_out <= 1'b0;
			dll_reset_out <= 1'b0;
			bifurcate_enable_out <= 1'b0;
			g3_idle_qualify_enable_out <= 1'b0;
		end else begin
			nullify_enable_out <= ctrl_q[0]; // [R9]
			dll_reset_out <= dll_rst_q; // [R10]
			bifurcate_enable_out <= ctrl_q[29]; // [R15]
			g3_idle_qualify_enable_out <= misc_q[7]; // [R18]
		end
	end

	// Transaction layer settings are registered copies of their fields.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			vga_decode_out <= 1'b0;
			msi_cap_hide_out <= 1'b0;
			pwr_cap_hide_out <= 1'b0;
			mem_share_dis_out <= 1'b0;
			ct_early_cycles_out <= 2'h0;
		end else begin
			vga_decode_out <= tla_q[0]; // [R19]
			msi_cap_hide_out <= tla_q[1]; // [R20]
			pwr_cap_hide_out <= tla_q[2]; // [R20]
			mem_share_dis_out <= tla_q[5]; // [R21]
			ct_early_cycles_out <= tlb_q[2:1]; // [R22]
		end
	end

	// Threshold and power management acknowledge counts.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			rx_threshold_out <= 4'h0;
			rx_pm_ack_out <= 3'h0;
			tx_pm_ack_out <= 3'h0;
		end else begin
			rx_threshold_out <= ctrl_q[7:4]; // [R12]
			rx_pm_ack_out <= rx_ack_q; // [R5]
			tx_pm_ack_out <= tx_ack_q; // [R6]
		end
	end

	// De-skew ranges per generation and the de-skew reset count.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			deskew_g1_out <= 4'h0;
			deskew_g2_out <= 4'h0;
			deskew_g3_out <= 4'h0;
			deskew_rst_cnt_out <= 3'h0;
		end else begin
			deskew_g1_out <= ctrl_q[19:16]; // [R13]
			deskew_g2_out <= ctrl_q[23:20]; // [R13]
			deskew_g3_out <= ctrl_q[27:24]; // [R13]
			deskew_rst_cnt_out <= misc_q[10:8]; // [R17]
		end
	end

	// Fast training sequence skew ranges.
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			fts_g1_out <= 3'h0;
			fts_g2_out <= 3'h0;
		end else begin
			fts_g1_out <= ctrl_q[12:10]; // [R14]
			fts_g2_out <= ctrl_q[15:13]; // [R14]
		end
	end

	always @* begin
		rdata_d = 32'h0000_0000;
		case (addr_in)
			`LTL_ADDR_MISC: rdata_d = rd_misc; // [R16]
			`LTL_ADDR_ERR: rdata_d = rd_err;
			`LTL_ADDR_NAK: rdata_d = rd_nak;
			`LTL_ADDR_CTRL: rdata_d = rd_ctrl;
			`LTL_ADDR_TXDBG: rdata_d = `LTL_RST_TXDBG;
			`LTL_ADDR_RXDBG: rdata_d = `LTL_RST_RXDBG;
			`LTL_ADDR_MTXDBG: rdata_d = `LTL_RST_MTXDBG;
			`LTL_ADDR_MRXDBG: rdata_d = `LTL_RST_MRXDBG;
			`LTL_ADDR_LADBG: rdata_d = ladbg_q;
			`LTL_ADDR_TLA: rdata_d = rd_tla;
			`LTL_ADDR_TLB: rdata_d = rd_tlb;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in) begin
			rdata_out <= rdata_d;
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

endmodule // ltl_link_txn_regs

// ---- testbench/ltl_link_txn_regs_monitor.sv ----
`timescale 1ns/1ps
`include "ltl_consts.vh"
module ltl_link_txn_regs_monitor (
	input wire ref_clk_in,
	input wire reset_in,
	input wire [11:0] addr_in,
	input wire [31:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [31:0] rdata_out,
	input wire dll_reset_req_in,
	input wire arb_credit_ok_in,
	input wire arb_req_pending_in,
	input wire arb_move_out,
	input wire nullify_enable_out,
	input wire dll_reset_out,
	input wire bifurcate_enable_out,
	input wire [2:0] fts_g1_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wire wc = wr_in && addr_in == `LTL_ADDR_CTRL;
	property p_rd_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_null; wc |=> ##1 nullify_enable_out == $past(wdata_in[0], 2); endproperty
	a_null: assert property (p_null) else $error("nullify enable wrong");
	property p_bif; wc |=> ##1 bifurcate_enable_out == $past(wdata_in[29], 2); endproperty
	a_bif: assert property (p_bif) else $error("bifurcation wrong");
	property p_fts; wc |=> ##1 fts_g1_out == $past(wdata_in[12:10], 2); endproperty
	a_fts: assert property (p_fts) else $error("fts range wrong");
	property p_dll_clr; wc && wdata_in[1] && !dll_reset_req_in |=> ##1 !dll_reset_out; endproperty
	a_dll_clr: assert property (p_dll_clr) else $error("dll reset not cleared");
	property p_dll_set; dll_reset_req_in |=> ##1 dll_reset_out; endproperty
	a_dll_set: assert property (p_dll_set) else $error("dll reset not set");
	property p_move_hi; !arb_req_pending_in && arb_credit_ok_in |-> arb_move_out; endproperty
	a_move_hi: assert property (p_move_hi) else $error("arbiter held");
	property p_move_lo; arb_req_pending_in && !arb_credit_ok_in |-> !arb_move_out; endproperty
	a_move_lo: assert property (p_move_lo) else $error("arbiter moved");
	cover property (dll_reset_req_in);
	cover property (rd_in ##2 wc);
	cover property (arb_req_pending_in && arb_move_out);
endmodule // ltl_link_txn_regs_monitor

// ---- testbench/ltl_link_txn_regs_tb.sv ----
`timescale 1ns/1ps
module ltl_link_txn_regs_tb;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} ltl_row_t;
	ltl_row_t rows [12] = '{
		'{1'h0, 12'h450, 32'h0, 32'h0000078D},
		'{1'h0, 12'h454, 32'h0, 32'h1F18B000},
		'{1'h0, 12'h458, 32'h0, 32'h0},
		'{1'h0, 12'h45C, 32'h0, 32'h0CCC2C81},
		'{1'h0, 12'h4C0, 32'h0, 32'h1},
		'{1'h0, 12'h4C4, 32'h0, 32'h8},
		'{1'h1, 12'h454, 32'h000753FF, 32'h1F18D000},
		'{1'h1, 12'h454, 32'h00067000, 32'h1F1ED000},
		'{1'h1, 12'h45C, 32'hFFFFFFFF, 32'h7FFFFFFD},
		'{1'h1, 12'h4C0, 32'hFFFFFFFF, 32'h701},
		'{1'h1, 12'h4C4, 32'hFFFFFFFF, 32'h1F},
		'{1'h1, 12'h474, 32'hFFFFFFFF, 32'h0}
	};
	logic ref_clk_in = 1'h0, reset_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0, dll_reset_req_in = 1'h0;
	logic [11:0] addr_in = 12'h0, rx_nak_seq_in = 12'h0, tx_nak_seq_in = 12'h0;
	logic [31:0] wdata_in = 32'h0, rdata_out;
	logic [9:0] err_event_in = 10'h0;
	logic rx_nak_in = 1'h0, tx_nak_in = 1'h0, x16_b2b_tlp_in = 1'h0, mem_share_dis_strap_in = 1'h0;
	logic [1:0] cap_dis_strap_in = 2'h0, ct_early_cycles_out;
	logic arb_credit_ok_in = 1'h0, arb_req_pending_in = 1'h0, arb_move_out, nullify_enable_out;
	logic dll_reset_out, bifurcate_enable_out, g3_idle_qualify_enable_out, vga_decode_out;
	logic msi_cap_hide_out, pwr_cap_hide_out, mem_share_dis_out;
	logic [3:0] rx_threshold_out, deskew_g1_out, deskew_g2_out, deskew_g3_out;
	logic [2:0] rx_pm_ack_out, tx_pm_ack_out, fts_g1_out, fts_g2_out, deskew_rst_cnt_out;
	int fails = 0;
	int n_compared = 0;
	wire [31:0] flds = {vga_decode_out, ct_early_cycles_out, rx_pm_ack_out, tx_pm_ack_out,
		bifurcate_enable_out, deskew_g3_out, deskew_g2_out, deskew_g1_out, fts_g2_out,
		fts_g1_out, rx_threshold_out};
	ltl_link_txn_regs dut_u (.*);
	always #5 ref_clk_in = ~ref_clk_in;
	task chk(input [31:0] s, input [31:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task wr(input [11:0] a, input [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'h1;
		cyc(1);
		wr_in <= 1'h0;
	endtask
	task rc(input [11:0] a, input [31:0] e);
		addr_in <= a;
		rd_in <= 1'h1;
		cyc(1);
		rd_in <= 1'h0;
		cyc(1);
		chk(rdata_out, e);
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		cyc(2);
		reset_in <= 1'h0;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		$display("table done");
		wr(12'h45C, 32'h23456A91);
		cyc(2);
		chk(flds, {1'h1, 2'h3, 3'h5, 3'h6, 1'h1, 4'h3, 4'h4, 4'h5, 3'h3, 3'h2, 4'h9});
		wr(12'h450, 32'h00000204);
		x16_b2b_tlp_in <= 1'h1;
		cyc(1);
		x16_b2b_tlp_in <= 1'h0;
		rc(12'h450, 32'h00000204);
		chk({28'h0, g3_idle_qualify_enable_out, deskew_rst_cnt_out}, 32'h2);
		wr(12'h450, 32'h0);
		x16_b2b_tlp_in <= 1'h1;
		cyc(3);
		x16_b2b_tlp_in <= 1'h0;
		rc(12'h450, 32'h30000000);
		$display("fields done");
		err_event_in <= 10'h155;
		cyc(1);
		err_event_in <= 10'h2AA;
		cyc(1);
		err_event_in <= 10'h0;
		rc(12'h454, 32'h1F1ED3FF);
		{rx_nak_in, tx_nak_in, rx_nak_seq_in, tx_nak_seq_in} <= {2'h3, 12'hABC, 12'h123};
		cyc(1);
		{rx_nak_in, tx_nak_in, rx_nak_seq_in, tx_nak_seq_in} <= {2'h0, 12'h555, 12'h555};
		rc(12'h458, 32'h81238ABC);
		dll_reset_req_in <= 1'h1;
		cyc(1);
		dll_reset_req_in <= 1'h0;
		cyc(2);
		chk({31'h0, dll_reset_out}, 32'h1);
		wr(12'h45C, 32'h00000002);
		rc(12'h45C, 32'h0);
		{cap_dis_strap_in, mem_share_dis_strap_in} <= 3'h7;
		cyc(6);
		rc(12'h4C0, 32'h00000727);
		chk({29'h0, msi_cap_hide_out, pwr_cap_hide_out, mem_share_dis_out}, 32'h7);
		$display("events done");
		for (int m = 0; m < 2; m++) begin
			wr(12'h4C4, {27'h0, m[0], 4'h0});
			for (int j = 0; j < 4; j++) begin
				{arb_req_pending_in, arb_credit_ok_in} <= j[1:0];
				@(negedge ref_clk_in);
				chk({31'h0, arb_move_out}, {31'h0, m[0] ? !j[1] : j[0]});
				cyc(1);
			end
		end
		$display("arbiter done");
		reset_in <= 1'h1;
		cyc(2);
		chk({31'h0, nullify_enable_out}, 32'h0);
		reset_in <= 1'h0;
		rc(12'h45C, 32'h0CCC2C81);
		cyc(1);
		chk({29'h0, nullify_enable_out, bifurcate_enable_out, dll_reset_out}, 32'h4);
		$display("reset done");
		end_of_test;
	end
endmodule // ltl_link_txn_regs_tb
bind ltl_link_txn_regs ltl_link_txn_regs_monitor mon_u (.*);
